// ==== inc/cbie_defs.svh ====
// Offsets, field positions and reset values of the buffer interrupt enables
`ifndef CBIE_DEFS_SVH
`define CBIE_DEFS_SVH
`define CBIE_ADDR_W         4
`define CBIE_OFF_TX_EN      4'h0
`define CBIE_OFF_BUF_EN     4'h1
`define CBIE_OFF_GROUP      4'h2
`define CBIE_OFF_STATUS     4'h3
`define CBIE_OFF_EVENTS     4'h4
`define CBIE_TX_EN_MASK     8'h1c
`define CBIE_TX_EN_LSB      2
`define CBIE_TX_EN_RESET    8'h00
`define CBIE_BUF_EN_RESET   8'h00
`define CBIE_GROUP_RESET    8'h00
`define CBIE_GROUP_TX_BIT   4
`define CBIE_GROUP_RX_BIT   1
`define CBIE_PROG_LSB       2
`define CBIE_RX_EN_LSB      0
`define CBIE_STATUS_TX_BIT  0
`define CBIE_STATUS_RX_BIT  1
`define CBIE_RDATA_RESET    8'h00
`endif

// ==== inc/cbie_pkg.sv ====
// Types shared by the buffer interrupt enable block
package cbie_pkg;
    typedef enum logic [1:0] {
        CBIE_MODE_LEGACY = 2'b00,
        CBIE_MODE_ENH1   = 2'b01,
        CBIE_MODE_ENH2   = 2'b10,
        CBIE_MODE_RSVD   = 2'b11
    } cbie_mode_t;
endpackage : cbie_pkg

// ==== src/cbie_irq_enable.sv ====
// Per-buffer interrupt enable gating for the CAN message buffers
//
// Operation
// - Both enable registers exist only in enhanced modes 1 and 2.
// - Transmit enable bits 4..2 enable transmit buffers 2, 1, 0.
// - Transmit enable bits 7..5 and 1..0 ignore writes, read zero.
// - Transmit buffer interrupt also needs the transmit group enable.
// - Buffer enable bits 7..2 enable programmable buffers 5..0.
// - Buffer enable bits 1..0 enable dedicated receive buffers 1, 0.
// - Buffer interrupt needs the matching transmit or receive group enable.
// - Transmit group enable low blocks every transmit buffer interrupt.
// - Receive group enable low blocks every receive buffer interrupt.
// - Any-transmit flag sets in modes 1 and 2 when any transmit buffer completes.
`include "cbie_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module cbie_irq_enable
    import cbie_pkg::*;
#(
    parameter int NUM_TX   = 3,
    parameter int NUM_PROG = 6,
    parameter int NUM_RX   = 2
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // Register port
    input  wire logic [`CBIE_ADDR_W-1:0] addr_in,
    input  wire logic [7:0]              wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic      [7:0]              rdata_out,
    // Controller mode
    input  wire logic [1:0]              mode_in,
    // Buffer events, one-cycle pulses from the controller
    input  wire logic [NUM_TX-1:0]       tx_done_in,
    input  wire logic [NUM_PROG-1:0]     prog_tx_done_in,
    input  wire logic [NUM_PROG-1:0]     prog_rx_done_in,
    input  wire logic [NUM_RX-1:0]       rx_done_in,
    // Interrupt requests and flags
    output logic                         tx_irq_out,
    output logic                         rx_irq_out,
    output logic                         any_tx_done_flag_out,
    output logic                         any_rx_done_flag_out
);
    // Mode decode, shared by write gating, read masking and requests
    function automatic logic is_enhanced(
        input cbie_mode_t m
    );
        return (m == CBIE_MODE_ENH1) || (m == CBIE_MODE_ENH2);
    endfunction : is_enhanced

    // Register index decode, used once per register
    function automatic logic index_hit(
        input logic [`CBIE_ADDR_W-1:0] index,
        input logic [`CBIE_ADDR_W-1:0] target
    );
        return index == target;
    endfunction : index_hit

    // Register state
    logic [7:0]          tx_buffer_irq_enables;
    logic [7:0]          buffer_irq_enables_0;
    logic [7:0]          periph_irq_enable_3;
    logic                any_tx_done_flag;
    logic                any_rx_done_flag;

    // Next values
    logic [7:0]          next_tx_buffer_irq_enables;
    logic [7:0]          next_buffer_irq_enables_0;
    logic [7:0]          next_periph_irq_enable_3;
    logic                next_any_tx_done_flag;
    logic                next_any_rx_done_flag;
    logic [7:0]          next_rdata;

    // Mode
    cbie_mode_t          mode;
    logic                enh_mode;

    // Index decode and write strobes
    logic                sel_tx_en;
    logic                sel_buf_en;
    logic                sel_group;
    logic                sel_status;
    logic                sel_events;
    logic                wr_tx_en;
    logic                wr_buf_en;
    logic                wr_group;
    logic                wr_status;

    // Enable fields
    logic [NUM_TX-1:0]   tx_buf_individual_enable;
    logic [NUM_PROG-1:0] prog_buf_individual_enable;
    logic [NUM_RX-1:0]   dedicated_rx_buf_enable;
    logic                tx_group_enable;
    logic                rx_group_enable;

    // Per-buffer gated events
    logic [NUM_TX-1:0]   tx_buf_hit;
    logic [NUM_PROG-1:0] prog_tx_hit;
    logic [NUM_PROG-1:0] prog_rx_hit;
    logic [NUM_RX-1:0]   rx_buf_hit;
    logic                tx_hit;
    logic                rx_hit;
    logic                tx_any_event;
    logic                rx_any_event;

    // Flag set and clear terms
    logic                tx_flag_set;
    logic                tx_flag_clear;
    logic                rx_flag_set;
    logic                rx_flag_clear;

    // Read paths
    logic [7:0]          rd_tx_en;
    logic [7:0]          rd_buf_en;
    logic [7:0]          rd_status;
    logic [7:0]          rd_events;

    assign mode     = cbie_mode_t'(mode_in);
    // Legacy and reserved modes hide both enable registers
    assign enh_mode = is_enhanced(mode);

    assign sel_tx_en  = index_hit(addr_in, `CBIE_OFF_TX_EN);
    assign sel_buf_en = index_hit(addr_in, `CBIE_OFF_BUF_EN);
    assign sel_group  = index_hit(addr_in, `CBIE_OFF_GROUP);
    assign sel_status = index_hit(addr_in, `CBIE_OFF_STATUS);
    assign sel_events = index_hit(addr_in, `CBIE_OFF_EVENTS);

    assign wr_tx_en  = wr_in && sel_tx_en && enh_mode;
    assign wr_buf_en = wr_in && sel_buf_en && enh_mode;
    assign wr_group  = wr_in && sel_group;
    assign wr_status = wr_in && sel_status;

    // Unimplemented bits never store, so no read mask can be forgotten
    assign next_tx_buffer_irq_enables =
        wr_tx_en ? (wdata_in & `CBIE_TX_EN_MASK)
                 : tx_buffer_irq_enables;
    assign next_buffer_irq_enables_0 =
        wr_buf_en ? wdata_in : buffer_irq_enables_0;
    assign next_periph_irq_enable_3 =
        wr_group ? wdata_in : periph_irq_enable_3;

    assign tx_buf_individual_enable =
        tx_buffer_irq_enables[`CBIE_TX_EN_LSB +: NUM_TX];
    assign prog_buf_individual_enable =
        buffer_irq_enables_0[`CBIE_PROG_LSB +: NUM_PROG];
    assign dedicated_rx_buf_enable =
        buffer_irq_enables_0[`CBIE_RX_EN_LSB +: NUM_RX];
    assign tx_group_enable =
        periph_irq_enable_3[`CBIE_GROUP_TX_BIT];
    assign rx_group_enable =
        periph_irq_enable_3[`CBIE_GROUP_RX_BIT];

    // One gate per buffer; programmable buffers count by event direction
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TX; gi = gi + 1) begin : g_tx_buf
            assign tx_buf_hit[gi] =
                tx_done_in[gi] && tx_buf_individual_enable[gi];
        end
        for (gi = 0; gi < NUM_PROG; gi = gi + 1) begin : g_prog_buf
            assign prog_tx_hit[gi] =
                prog_tx_done_in[gi]
                && prog_buf_individual_enable[gi];
            assign prog_rx_hit[gi] =
                prog_rx_done_in[gi]
                && prog_buf_individual_enable[gi];
        end
        for (gi = 0; gi < NUM_RX; gi = gi + 1) begin : g_rx_buf
            assign rx_buf_hit[gi] =
                rx_done_in[gi] && dedicated_rx_buf_enable[gi];
        end
    endgenerate

    assign tx_hit = (|tx_buf_hit) || (|prog_tx_hit);
    assign rx_hit = (|rx_buf_hit) || (|prog_rx_hit);
    assign tx_any_event = (|tx_done_in) || (|prog_tx_done_in);
    assign rx_any_event = (|rx_done_in) || (|prog_rx_done_in);

    // Group enable low overrides every individual enable
    assign tx_irq_out =
        enh_mode && tx_group_enable && tx_hit;
    assign rx_irq_out =
        enh_mode && rx_group_enable && rx_hit;

    // Set beats clear, so an event in the clearing cycle is never lost
    assign tx_flag_set   = enh_mode && tx_any_event;
    assign tx_flag_clear = wr_status && !wdata_in[`CBIE_STATUS_TX_BIT];
    assign rx_flag_set   = enh_mode && rx_any_event;
    assign rx_flag_clear = wr_status && !wdata_in[`CBIE_STATUS_RX_BIT];

    assign next_any_tx_done_flag =
        tx_flag_set   ? 1'b1 :
        tx_flag_clear ? 1'b0 :
                        any_tx_done_flag;
    assign next_any_rx_done_flag =
        rx_flag_set   ? 1'b1 :
        rx_flag_clear ? 1'b0 :
                        any_rx_done_flag;

    assign any_tx_done_flag_out = any_tx_done_flag;
    assign any_rx_done_flag_out = any_rx_done_flag;

    // Enable registers keep contents outside modes 1/2 but read as zero
    assign rd_tx_en =
        enh_mode ? (tx_buffer_irq_enables & `CBIE_TX_EN_MASK)
                 : 8'h00;
    assign rd_buf_en =
        enh_mode ? buffer_irq_enables_0 : 8'h00;
    assign rd_status =
        {6'h00, any_rx_done_flag, any_tx_done_flag};
    assign rd_events =
        {6'h00, rx_irq_out, tx_irq_out};

    // Read data is zero except in the cycle after a read strobe
    assign next_rdata =
        !rd_in     ? 8'h00 :
        sel_tx_en  ? rd_tx_en :
        sel_buf_en ? rd_buf_en :
        sel_group  ? periph_irq_enable_3 :
        sel_status ? rd_status :
        sel_events ? rd_events :
                     8'h00;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_buffer_irq_enables <= `CBIE_TX_EN_RESET;
        end else begin
            tx_buffer_irq_enables <= next_tx_buffer_irq_enables;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            buffer_irq_enables_0 <= `CBIE_BUF_EN_RESET;
        end else begin
            buffer_irq_enables_0 <= next_buffer_irq_enables_0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            periph_irq_enable_3 <= `CBIE_GROUP_RESET;
        end else begin
            periph_irq_enable_3 <= next_periph_irq_enable_3;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            any_tx_done_flag <= 1'b0;
        end else begin
            any_tx_done_flag <= next_any_tx_done_flag;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            any_rx_done_flag <= 1'b0;
        end else begin
            any_rx_done_flag <= next_any_rx_done_flag;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= `CBIE_RDATA_RESET;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    // Requests are combinational, so they appear in the event cycle
    // itself; a downstream controller that needs a clean level must
    // register them on its own side.

    // Programmable buffers share one enable for both directions; a
    // buffer switched between transmit and receive keeps its enable.

    // Reserved mode is treated like legacy mode: nothing is gated on.

endmodule : cbie_irq_enable
`default_nettype wire

// ==== tb/cbie_irq_sva.sv ====
// Port checker for the buffer interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module cbie_irq_sva #(parameter int NUM_TX = 3, parameter int NUM_PROG = 6) (
    // Inputs and outputs of the block, grouped to keep the file short
    input wire logic                clk_in, reset_in, wr_in, rd_in,
    input wire logic [3:0]          addr_in,
    input wire logic [7:0]          wdata_in, rdata_out,
    input wire logic [1:0]          mode_in,
    input wire logic [NUM_TX-1:0]   tx_done_in,
    input wire logic [NUM_PROG-1:0] prog_tx_done_in,
    input wire logic                tx_irq_out, rx_irq_out, any_tx_done_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire enh = mode_in == 2'h1 || mode_in == 2'h2;
    sequence s_tx_off; wr_in && addr_in == 4'h2 && !wdata_in[4]; endsequence
    sequence s_rx_off; wr_in && addr_in == 4'h2 && !wdata_in[1]; endsequence
    AST_TX_RSVD: assert property (rd_in && addr_in == 4'h0 |=>
        (rdata_out & 8'he3) == 8'h00) else $error("reserved bits read set");
    AST_MODE_RD: assert property (rd_in && addr_in < 4'h2 && !enh |=>
        rdata_out == 8'h00) else $error("enable read outside modes 1/2");
    AST_MODE_IRQ: assert property (!enh |-> !tx_irq_out && !rx_irq_out)
        else $error("request outside modes 1/2");
    AST_TX_CAUSE: assert property (tx_irq_out |->
        |{tx_done_in, prog_tx_done_in}) else $error("tx request without event");
    AST_TX_FLAG: assert property (enh && |tx_done_in |=>
        any_tx_done_flag_out) else $error("tx flag not set");
    AST_LIVE_RD: assert property (rd_in && addr_in == 4'h4 |=>
        rdata_out == {6'h00, $past(rx_irq_out), $past(tx_irq_out)})
        else $error("live request read wrong");
    AST_GRP_TX: assert property (s_tx_off |=> !tx_irq_out)
        else $error("tx request with group off");
    AST_GRP_RX: assert property (s_rx_off |=> !rx_irq_out)
        else $error("rx request with group off");
endmodule : cbie_irq_sva
bind cbie_irq_enable cbie_irq_sva #(.NUM_TX(NUM_TX), .NUM_PROG(NUM_PROG)) u_sva (
    .clk_in(clk_in), .reset_in(reset_in), .wr_in(wr_in), .rd_in(rd_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .mode_in(mode_in), .tx_done_in(tx_done_in),
    .prog_tx_done_in(prog_tx_done_in), .tx_irq_out(tx_irq_out),
    .rx_irq_out(rx_irq_out), .any_tx_done_flag_out(any_tx_done_flag_out));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Random self-checking bench with a reference model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 0, rst = 1, wr = 0, rd = 0, txi, rxi, txf, rxf, e, xt, xr;
    logic [3:0] addr = 0;
    logic [7:0] wd = 0, rdata, tb_r = 0, bi = 0, g = 0, er = 0;
    logic [1:0] mode = 0, rxd = 0, ftx = 0, frx = 0;
    logic [2:0] txd = 0;
    logic [5:0] ptd = 0, prd = 0;
    int seed = 71, errors = 0, compares = 0, op;
    cbie_irq_enable u_dut (.clk_in(clk), .reset_in(rst), .addr_in(addr),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .mode_in(mode), .tx_done_in(txd), .prog_tx_done_in(ptd),
        .prog_rx_done_in(prd), .rx_done_in(rxd), .tx_irq_out(txi),
        .rx_irq_out(rxi), .any_tx_done_flag_out(txf),
        .any_rx_done_flag_out(rxf));
    initial forever #4 clk = ~clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task summarize;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        #20000 errors++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (1500) begin
            @(posedge clk);
            op = {$random(seed)} % 3;
            wr <= op == 1;
            rd <= op == 2;
            addr <= 4'({$random(seed)} % 6);
            wd <= 8'($random(seed));
            mode <= 2'($random(seed));
            txd <= 3'($random(seed) & $random(seed));
            ptd <= 6'($random(seed) & $random(seed));
            prd <= 6'($random(seed) & $random(seed));
            rxd <= 2'($random(seed));
            @(negedge clk);
            e = mode == 2'h1 || mode == 2'h2;
            xt = e && g[4] && |((txd & tb_r[4:2]) | (ptd & bi[7:2]));
            xr = e && g[1] && |({rxd & bi[1:0]} | (prd & bi[7:2]));
            chk(8'(txi), 8'(xt));
            chk(8'(rxi), 8'(xr));
            chk(rdata, er);
            chk({rxf, txf}, {frx[0], ftx[0]});
            er = !rd ? 8'h00 : addr == 0 ? (e ? tb_r : 8'h00) :
                addr == 1 ? (e ? bi : 8'h00) : addr == 2 ? g :
                addr == 3 ? {6'h00, frx[0], ftx[0]} :
                addr == 4 ? {6'h00, xr, xt} : 8'h00;
            if (wr && e && addr == 0) tb_r = wd & 8'h1c;
            if (wr && e && addr == 1) bi = wd;
            if (wr && addr == 2) g = wd;
            if (wr && addr == 3) {frx, ftx} = {frx & wd[1], ftx & wd[0]};
            ftx = ftx | (e && |{txd, ptd});
            frx = frx | (e && |{rxd, prd});
        end
        $display("random register and event test done");
        summarize;
    end
endmodule : tb_top
`default_nettype wire
